// ---- rtl/mmsb_pkg.sv ----
// Shared constants and types for the burst slave port and its fabric end.
package mmsb_pkg;
   localparam int MMSB_ADDR_W  = 16;
   localparam int MMSB_DATA_W  = 32;
   localparam int MMSB_BE_W    = 4;
   localparam int MMSB_LEN_W   = 8;
   localparam int MMSB_FIFO_D  = 32;
   localparam int MMSB_RD_LAT  = 2;
   localparam logic [MMSB_BE_W-1:0] MMSB_BE_ALL = 4'hf;
   localparam logic [MMSB_LEN_W-1:0] MMSB_LEN_ZERO = 8'h00;
   localparam logic [MMSB_LEN_W-1:0] MMSB_LEN_ONE  = 8'h01;

   typedef enum logic [2:0] {
      MMSB_IDLE  = 3'h1,
      MMSB_WRITE = 3'h2,
      MMSB_READ  = 3'h4
   } mmsb_state_t;
endpackage : mmsb_pkg

// ---- rtl/mmsb_link_if.sv ----
// Link between the fabric end and the burst slave port.
`timescale 1ns/1ps
interface mmsb_link_if
   import mmsb_pkg::*;
();
   logic                   chipSelect;
   logic [MMSB_ADDR_W-1:0] address;
   logic [MMSB_BE_W-1:0]   byteEnable;
   logic [MMSB_DATA_W-1:0] writeData;
   logic                   write;
   logic                   read;
   logic [MMSB_LEN_W-1:0]  burstCount;
   logic                   beginBurst;
   logic                   waitRequest;
   logic [MMSB_DATA_W-1:0] readData;
   logic                   readDataValid;

   modport slave (
      input  chipSelect, address, byteEnable, writeData, write, read,
      input  burstCount, beginBurst,
      output waitRequest, readData, readDataValid
   );
   modport fabric (
      output chipSelect, address, byteEnable, writeData, write, read,
      output burstCount, beginBurst,
      input  waitRequest, readData, readDataValid
   );
endinterface : mmsb_link_if

// ---- rtl/mmsb_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module mmsb_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0]   count;
   } mmsb_fifo_st_t;

   logic [WIDTH-1:0] mem [DEPTH];
   mmsb_fifo_st_t    st_ff;
   mmsb_fifo_st_t    nxt_st;
   logic             doPush;
   logic             doPop;

   assign inReady  = (st_ff.count != (AW+1)'(DEPTH));
   assign outValid = (st_ff.count != '0);
   assign outData  = mem[st_ff.rdPtr];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   always_comb begin
      nxt_st = st_ff;
      if (doPush) begin
         nxt_st.wrPtr = (st_ff.wrPtr == AW'(DEPTH-1)) ? '0 : st_ff.wrPtr + 1'b1;
      end
      if (doPop) begin
         nxt_st.rdPtr = (st_ff.rdPtr == AW'(DEPTH-1)) ? '0 : st_ff.rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
         nxt_st.count = st_ff.count + 1'b1;
      end else if (doPop && !doPush) begin
         nxt_st.count = st_ff.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
      if (doPush) begin
         mem[st_ff.wrPtr] <= inData;
      end
   end
endmodule : mmsb_fifo

// ---- rtl/mmsb_slave.sv ----
// Burst slave port: captures one command per burst and moves N units.
`timescale 1ns/1ps
module mmsb_slave
   import mmsb_pkg::*;
#(
   parameter bit DYN_SIZING = 1'b1,
   parameter int FIFO_DEPTH = MMSB_FIFO_D
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Link
   mmsb_link_if.slave                  link,
   // User write side
   output logic                        userWrValid,
   output logic [MMSB_ADDR_W-1:0]      userWrAddr,
   output logic [MMSB_DATA_W-1:0]      userWrData,
   // User read side
   output logic                        userRdReq,
   output logic [MMSB_ADDR_W-1:0]      userRdAddr,
   input  wire logic [MMSB_DATA_W-1:0] userRdData,
   // Status
   output logic                        busy
);
   typedef struct packed {
      mmsb_state_t            state;
      logic [MMSB_ADDR_W-1:0] addr;
      logic [MMSB_LEN_W-1:0]  remain;
      logic                   waitReq;
      logic                   rdValid;
      logic [MMSB_DATA_W-1:0] rdData;
      logic                   wrValid;
      logic [MMSB_ADDR_W-1:0] wrAddr;
      logic [MMSB_DATA_W-1:0] wrData;
      logic                   rdReq;
      logic [MMSB_ADDR_W-1:0] rdAddr;
      logic [MMSB_RD_LAT-1:0] rdPipe;
      logic                   busy;
   } mmsb_slave_st_t;

   mmsb_slave_st_t         st_ff;
   mmsb_slave_st_t         nxt_st;
   logic                   fifoInReady;
   logic                   fifoOutValid;
   logic [MMSB_DATA_W-1:0] fifoOutData;
   logic                   wrTaken;

   function automatic logic [MMSB_ADDR_W-1:0] nextAddr(
      input logic [MMSB_ADDR_W-1:0] a);
      nextAddr = DYN_SIZING ? a + 1'b1 : a;
   endfunction : nextAddr

   // Read data returns through the FIFO; the drain is tied ready, so it
   // never stalls and each stored unit leaves on the next edge.
   mmsb_fifo #(
      .WIDTH (MMSB_DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rdFifo (
      .clk      (clk),
      .reset    (reset),
      .inValid  (st_ff.rdPipe[MMSB_RD_LAT-1]),
      .inReady  (fifoInReady),
      .inData   (userRdData),
      .outValid (fifoOutValid),
      .outReady (1'b1),
      .outData  (fifoOutData)
   );

   // A write unit counts only when the slave is not stalling.
   assign wrTaken = link.write && link.chipSelect && !st_ff.waitReq;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.wrValid = 1'b0;
      nxt_st.rdReq   = 1'b0;
      nxt_st.rdValid = fifoOutValid;
      nxt_st.rdData  = fifoOutData;
      nxt_st.rdPipe  = {st_ff.rdPipe[MMSB_RD_LAT-2:0], st_ff.rdReq};
      // Stall new read and write commands while the read FIFO is full.
      nxt_st.waitReq = !fifoInReady;
      case (st_ff.state)
         MMSB_IDLE: begin
            if (wrTaken && link.burstCount != MMSB_LEN_ZERO) begin
               nxt_st.addr    = nextAddr(link.address);
               nxt_st.wrValid = 1'b1;
               nxt_st.wrAddr  = link.address;
               nxt_st.wrData  = link.writeData;
               nxt_st.remain  = link.burstCount - MMSB_LEN_ONE;
               nxt_st.state   = (link.burstCount == MMSB_LEN_ONE) ?
                                MMSB_IDLE : MMSB_WRITE;
            end else if (link.read && link.chipSelect && !st_ff.waitReq &&
                         link.burstCount != MMSB_LEN_ZERO) begin
               nxt_st.addr   = link.address;
               nxt_st.remain = link.burstCount;
               nxt_st.state  = MMSB_READ;
               nxt_st.waitReq = 1'b1;
            end
         end
         MMSB_WRITE: begin
            if (wrTaken) begin
               nxt_st.wrValid = 1'b1;
               nxt_st.wrAddr  = st_ff.addr;
               nxt_st.wrData  = link.writeData;
               nxt_st.addr    = nextAddr(st_ff.addr);
               nxt_st.remain  = st_ff.remain - MMSB_LEN_ONE;
               if (st_ff.remain == MMSB_LEN_ONE) begin
                  nxt_st.state = MMSB_IDLE;
               end
            end
         end
         MMSB_READ: begin
            // Commands wait until all reads of the burst are issued.
            nxt_st.waitReq = 1'b1;
            if (fifoInReady && st_ff.remain != MMSB_LEN_ZERO) begin
               nxt_st.rdReq  = 1'b1;
               nxt_st.rdAddr = st_ff.addr;
               nxt_st.addr   = nextAddr(st_ff.addr);
               nxt_st.remain = st_ff.remain - MMSB_LEN_ONE;
            end
            if (st_ff.remain == MMSB_LEN_ONE ||
                st_ff.remain == MMSB_LEN_ZERO) begin
               nxt_st.state   = MMSB_IDLE;
               nxt_st.waitReq = 1'b1;
            end
         end
         default: begin
            nxt_st.state = MMSB_IDLE;
         end
      endcase
      nxt_st.busy = (nxt_st.state != MMSB_IDLE) || nxt_st.rdReq ||
                    (nxt_st.rdPipe != '0) || fifoOutValid;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff       <= '0;
         st_ff.state <= MMSB_IDLE;
         st_ff.waitReq <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.waitRequest   = st_ff.waitReq;
   assign link.readData      = st_ff.rdData;
   assign link.readDataValid = st_ff.rdValid;
   assign userWrValid        = st_ff.wrValid;
   assign userWrAddr         = st_ff.wrAddr;
   assign userWrData         = st_ff.wrData;
   assign userRdReq          = st_ff.rdReq;
   assign userRdAddr         = st_ff.rdAddr;
   assign busy               = st_ff.busy;
endmodule : mmsb_slave

// ---- rtl/mmsb_fabric.sv ----
// Fabric end: drives one burst command at a time toward the slave.
`timescale 1ns/1ps
module mmsb_fabric
   import mmsb_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Link
   mmsb_link_if.fabric                 link,
   // User command
   input  wire logic                   cmdValid,
   input  wire logic                   cmdWrite,
   input  wire logic [MMSB_ADDR_W-1:0] cmdAddr,
   input  wire logic [MMSB_LEN_W-1:0]  cmdLen,
   output logic                        cmdReady,
   // User write data
   input  wire logic                   wdValid,
   input  wire logic [MMSB_DATA_W-1:0] wdData,
   output logic                        wdReady,
   // User read data
   output logic                        rdValid,
   output logic [MMSB_DATA_W-1:0]      rdData
);
   typedef struct packed {
      mmsb_state_t            state;
      logic                   cs;
      logic                   wr;
      logic                   rd;
      logic                   bgn;
      logic [MMSB_ADDR_W-1:0] addr;
      logic [MMSB_LEN_W-1:0]  len;
      logic [MMSB_DATA_W-1:0] wdata;
      logic [MMSB_LEN_W-1:0]  remain;
      logic                   rdValid;
      logic [MMSB_DATA_W-1:0] rdData;
   } mmsb_fabric_st_t;

   mmsb_fabric_st_t st_ff;
   mmsb_fabric_st_t nxt_st;
   logic            accepted;

   assign accepted = (st_ff.wr || st_ff.rd) && !link.waitRequest;
   assign cmdReady = (st_ff.state == MMSB_IDLE) && !st_ff.rd;
   // The first unit is taken only together with its command, and no unit
   // is taken on the edge that retires the last beat of a burst.
   assign wdReady  = (st_ff.state == MMSB_IDLE) ?
                     (cmdValid && cmdWrite && !st_ff.rd &&
                      cmdLen != MMSB_LEN_ZERO) :
                     (st_ff.state == MMSB_WRITE &&
                      (!st_ff.wr ||
                       (accepted && st_ff.remain != MMSB_LEN_ONE)));

   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdValid = link.readDataValid;
      nxt_st.rdData  = link.readData;
      case (st_ff.state)
         MMSB_IDLE: begin
            if (st_ff.rd && accepted) begin
               nxt_st.rd = 1'b0;
               nxt_st.cs = 1'b0;
               nxt_st.bgn = 1'b0;
            end else if (st_ff.rd) begin
               nxt_st.bgn = 1'b0;
            end else if (cmdValid && cmdLen != MMSB_LEN_ZERO &&
                         (!cmdWrite || wdValid)) begin
               nxt_st.addr = cmdAddr;
               nxt_st.len  = cmdLen;
               nxt_st.bgn  = 1'b1;
               nxt_st.cs   = 1'b1;
               nxt_st.wr   = cmdWrite;
               nxt_st.rd   = !cmdWrite;
               nxt_st.wdata = wdData;
               nxt_st.remain = cmdLen;
               nxt_st.state = cmdWrite ? MMSB_WRITE : MMSB_IDLE;
            end
         end
         MMSB_WRITE: begin
            if (st_ff.wr && !accepted) begin
               nxt_st.bgn = 1'b0;
            end else begin
               if (accepted) begin
                  nxt_st.remain = st_ff.remain - MMSB_LEN_ONE;
                  nxt_st.bgn = 1'b0;
               end
               if (accepted && st_ff.remain == MMSB_LEN_ONE) begin
                  nxt_st.wr = 1'b0;
                  nxt_st.cs = 1'b0;
                  nxt_st.state = MMSB_IDLE;
               end else begin
                  nxt_st.wr = wdValid;
                  nxt_st.cs = wdValid;
                  nxt_st.wdata = wdData;
               end
            end
         end
         default: begin
            nxt_st.state = MMSB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff       <= '0;
         st_ff.state <= MMSB_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.chipSelect = st_ff.cs;
   assign link.address    = st_ff.addr;
   assign link.byteEnable = MMSB_BE_ALL;
   assign link.writeData  = st_ff.wdata;
   assign link.write      = st_ff.wr;
   assign link.read       = st_ff.rd;
   assign link.burstCount = st_ff.len;
   assign link.beginBurst = st_ff.bgn;
   assign rdValid         = st_ff.rdValid;
   assign rdData          = st_ff.rdData;
endmodule : mmsb_fabric

// ---- tb/mmsb_link_sva.sv ----
// Link checker: watches the burst port link between fabric and slave.
`timescale 1ns/1ps
module mmsb_link_sva
   import mmsb_pkg::*;
(
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   reset,
   // Fabric side
   input wire logic                   chipSelect,
   input wire logic [MMSB_ADDR_W-1:0] address,
   input wire logic [MMSB_BE_W-1:0]   byteEnable,
   input wire logic [MMSB_DATA_W-1:0] writeData,
   input wire logic                   write,
   input wire logic                   read,
   input wire logic [MMSB_LEN_W-1:0]  burstCount,
   input wire logic                   beginBurst,
   // Slave side
   input wire logic                   waitRequest,
   input wire logic [MMSB_DATA_W-1:0] readData,
   input wire logic                   readDataValid
);
   logic [15:0] wrLeft_ff;
   logic [15:0] rdLeft_ff;
   logic        cmdAcc;
   logic        unitAcc;

   // Read units still owed may span a posted command, so they accumulate.
   assign cmdAcc  = chipSelect & !waitRequest & (read | write)
                    & (wrLeft_ff == 16'h0) & (burstCount != MMSB_LEN_ZERO);
   assign unitAcc = chipSelect & write & !waitRequest & (wrLeft_ff != 16'h0);

   always_ff @(posedge clk) begin
      if (reset) begin
         wrLeft_ff <= 16'h0;
         rdLeft_ff <= 16'h0;
      end else begin
         if (cmdAcc & write) begin
            wrLeft_ff <= 16'(burstCount) - 16'h1;
         end else if (unitAcc) begin
            wrLeft_ff <= wrLeft_ff - 16'h1;
         end
         rdLeft_ff <= rdLeft_ff + ((cmdAcc & read) ? 16'(burstCount) : 16'h0)
                      - (readDataValid ? 16'h1 : 16'h0);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   lanes_on_a: assert property (chipSelect |-> byteEnable == MMSB_BE_ALL)
      else $error("byte lanes not all enabled");
   cs_mirror_a: assert property (chipSelect == (write | read))
      else $error("chip select differs from strobes");
   hold_on_wait_a: assert property (chipSelect && waitRequest |=>
      $stable({chipSelect, write, read, address, writeData, byteEnable,
               burstCount}))
      else $error("fabric changed outputs while stalled");
   burst_start_a: assert property (beginBurst |->
      chipSelect && wrLeft_ff == 16'h0)
      else $error("start strobe outside a command");
   start_once_a: assert property (beginBurst && write && !waitRequest
      && burstCount > MMSB_LEN_ONE |=> !beginBurst)
      else $error("start strobe held past first cycle");
   rd_extra_a: assert property (readDataValid |-> rdLeft_ff != 16'h0)
      else $error("read unit beyond burst length");
   rd_flow_a: assert property (rdLeft_ff != 16'h0 |->
      ##[0:40] readDataValid)
      else $error("read units stopped flowing");
   wr_lock_a: assert property (wrLeft_ff != 16'h0 |-> !read)
      else $error("read during locked write burst");

   cover property (cmdAcc && write && burstCount > MMSB_LEN_ONE);
   cover property (cmdAcc && read && burstCount > MMSB_LEN_ONE);
   cover property (readDataValid && rdLeft_ff == 16'h1);
   cover property (chipSelect && waitRequest ##1 !waitRequest);
endmodule : mmsb_link_sva

// ---- tb/mm_slave_burst_port_test.sv ----
// Self-checking bench: fabric end and burst slave joined by the link.
`timescale 1ns/1ps
module mm_slave_burst_port_test;
   import mmsb_pkg::*;
   logic                   clk, reset, cmdValid, cmdWrite, cmdReady;
   logic                   wdValid, wdReady, rdValid;
   logic                   userWrValid, userRdReq, busy;
   logic [MMSB_ADDR_W-1:0] cmdAddr, userWrAddr, userRdAddr, rdAddrQ;
   logic [MMSB_LEN_W-1:0]  cmdLen;
   logic [MMSB_DATA_W-1:0] wdData, rdData, userWrData, userRdData;
   logic [47:0]            expWr[$];
   logic [47:0]            expRd[$];
   int                     err_count, samples_checked;

   mmsb_link_if link_i ();
   mmsb_fabric mmsb_fabric_i (.clk(clk), .reset(reset), .link(link_i.fabric),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
      .cmdLen(cmdLen), .cmdReady(cmdReady), .wdValid(wdValid),
      .wdData(wdData), .wdReady(wdReady), .rdValid(rdValid), .rdData(rdData));
   mmsb_slave #(.DYN_SIZING(1'b1), .FIFO_DEPTH(MMSB_FIFO_D)) mmsb_slave_i (
      .clk(clk), .reset(reset), .link(link_i.slave),
      .userWrValid(userWrValid), .userWrAddr(userWrAddr),
      .userWrData(userWrData), .userRdReq(userRdReq),
      .userRdAddr(userRdAddr), .userRdData(userRdData), .busy(busy));
   mmsb_link_sva mmsb_link_sva_i (.clk(clk), .reset(reset),
      .chipSelect(link_i.chipSelect), .address(link_i.address),
      .byteEnable(link_i.byteEnable), .writeData(link_i.writeData),
      .write(link_i.write), .read(link_i.read),
      .burstCount(link_i.burstCount), .beginBurst(link_i.beginBurst),
      .waitRequest(link_i.waitRequest), .readData(link_i.readData),
      .readDataValid(link_i.readDataValid));

   always #20 clk = ~clk;

   function automatic logic [31:0] memWord(input logic [15:0] a);
      return {a ^ 16'h5a5a, a};
   endfunction : memWord

   // User memory answers two cycles after each read request.
   always @(posedge clk) begin
      rdAddrQ    <= userRdAddr;
      userRdData <= memWord(rdAddrQ);
   end

   task automatic check(input logic [47:0] seen, input logic [47:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask : check

   task automatic give_verdict();
      $display("Checked %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic wait_hs(input bit useCmd);
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge clk);
         if ((useCmd ? cmdReady : wdReady) === 1'b1) break;
      end
      if (n == 300) begin
         err_count++;
         give_verdict();
      end
   endtask : wait_hs

   always @(posedge clk) begin
      if (userWrValid === 1'b1 && !reset) begin
         if (expWr.size() == 0) check(48'h1, 48'h0);
         else check({userWrAddr, userWrData}, expWr.pop_front());
      end
      if (rdValid === 1'b1 && !reset) begin
         if (expRd.size() == 0) check(48'h1, 48'h0);
         else check(48'(rdData), expRd.pop_front());
      end
   end

   task automatic burst(input bit wr, input logic [15:0] a,
                        input logic [7:0] len);
      int          gap;
      logic [31:0] d;
      if (!wr) for (int i = 0; i < len; i++)
         expRd.push_back(48'(memWord(a + 16'(i))));
      fork
         begin
            cmdValid <= 1'b1;
            cmdWrite <= wr;
            cmdAddr  <= a;
            cmdLen   <= len;
            wait_hs(1'b1);
            cmdValid <= 1'b0;
         end
         if (wr) begin
            for (int j = 0; j < len; j++) begin
               gap = $urandom % 3;
               d   = $urandom;
               if (j > 0 && gap != 0) begin
                  wdValid <= 1'b0;
                  repeat (gap) @(posedge clk);
               end
               wdValid <= 1'b1;
               wdData  <= d;
               wait_hs(1'b0);
               expWr.push_back({a + 16'(j), d});
            end
            wdValid <= 1'b0;
         end
      join
      // One edge passes so the next call never reassigns a strobe at once.
      @(posedge clk);
   endtask : burst

   task automatic end_test(input string name);
      int n;
      for (n = 0; n < 600; n++) begin
         @(posedge clk);
         if (busy === 1'b0 && expWr.size() == 0 && expRd.size() == 0) break;
      end
      if (n == 600) err_count++;
      check(48'({busy, cmdReady}), 48'h1);
      $display("Test %s finished at %0t", name, $time);
   endtask : end_test

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdAddr = '0;
      cmdLen = '0;
      wdValid = 1'b0;
      wdData = '0;
      userRdData = '0;
      rdAddrQ = '0;
      err_count = 0;
      samples_checked = 0;
      void'($urandom(45619));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      burst(1'b1, 16'h1000, 8'h01);
      end_test("write single");
      burst(1'b1, 16'h1000, 8'h04);
      end_test("write four");
      burst(1'b0, 16'h2000, 8'h01);
      end_test("read single");
      burst(1'b0, 16'hfffe, 8'h04);
      end_test("read wrap");
      burst(1'b0, 16'h3000, 8'h28);
      end_test("read past buffer");
      burst(1'b0, 16'h4000, 8'h08);
      burst(1'b1, 16'h5000, 8'h03);
      end_test("overlap");
      burst(1'b1, 16'h6000, 8'hff);
      end_test("write longest");
      for (int k = 0; k < 8; k++) begin
         burst(1'($urandom), 16'($urandom), 8'($urandom % 12 + 1));
      end
      end_test("random");
      give_verdict();
   end
endmodule : mm_slave_burst_port_test
